/* logic/pwmosd_top.v */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "pwmosd_regs.vh"

// Functional notes
// (RL1) Each active PWM edge is postponed by the 7-bit delay count in instruction cycles.
// (RL2) With sync set, written steering enables take effect at the next PWM period start.
// (RL3) A set steering enable drives its pin with the PWM waveform, polarity from mode bits 1:0.
// (RL4) A clear steering enable returns its pin to ordinary port control.
// (RL5) Steering acts only when mode bits 3:2 are 11 and the bridge field is 00.
// (RL6) With sync clear, steering changes apply at the next instruction cycle boundary.
module pwmosd_top #(
    parameter DELAY_W = 7,
    parameter PINS    = 4
) (
    // Clock and reset
    input  wire            clk_sys_in,
    input  wire            reset_n_in,
    // APB slave
    input  wire            psel_in,
    input  wire            penable_in,
    input  wire            pwrite_in,
    input  wire [11:0]     paddr_in,
    input  wire [31:0]     pwdata_in,
    output reg  [31:0]     prdata_out,
    output reg             pready_out,
    output reg             pslverr_out,
    // PWM core
    input  wire            pwm_raw_in,
    input  wire            period_start_in,
    // Port pin fallback
    input  wire [PINS-1:0] port_data_in,
    // Output pins
    output reg  [PINS-1:0] pwm_pin_out,
    output reg  [PINS-1:0] pwm_pin_owned_out,
    output reg             restart_enable_out
);

    reg  [7:0]      delay_ctrl_q;
    reg  [4:0]      steer_wr_q;
    reg  [PINS-1:0] steer_act_q;
    reg             steer_pend_q;
    reg  [3:0]      mode_q;
    reg  [1:0]      bridge_q;
    reg  [1:0]      div_q;
    reg             cycle_en_q;
    reg             period_seen_q;
    wire            pwm_dly;
    wire            steer_mode;
    wire            wr_acc;
    wire            rd_acc;
    reg  [31:0]     rdata_d;
    reg             addr_ok_d;

    localparam [4:0] STEER_RST = `PWMOSD_STEER_RESET;

    // ----------------------------------------
    // Instruction cycle enable
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q      <= 2'h0;
            cycle_en_q <= 1'b0;
        end else begin
            div_q      <= (div_q == `PWMOSD_CYCLE_DIV) ? 2'h0 : div_q + 2'h1;
            cycle_en_q <= (div_q == `PWMOSD_CYCLE_DIV);
        end
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign wr_acc = psel_in & penable_in & pwrite_in & pready_out;
    assign rd_acc = psel_in & penable_in & ~pwrite_in & pready_out;

    always @* begin
        rdata_d   = 32'h0000_0000;
        addr_ok_d = 1'b1;
        if (paddr_in == `PWMOSD_DELAY_CTRL_ADDR) begin
            rdata_d[7:0] = delay_ctrl_q;
        end else if (paddr_in == `PWMOSD_STEER_CTRL_ADDR) begin
            rdata_d[4:0] = steer_wr_q;
        end else if (paddr_in == `PWMOSD_MODE_CTRL_ADDR) begin
            rdata_d[`PWMOSD_MODE_MSB:`PWMOSD_MODE_LSB]     = mode_q;
            rdata_d[`PWMOSD_BRIDGE_MSB:`PWMOSD_BRIDGE_LSB] = bridge_q;
        end else if (paddr_in == `PWMOSD_STATUS_ADDR) begin
            rdata_d[PINS-1:0] = steer_act_q;
            rdata_d[4]        = steer_pend_q;
            rdata_d[5]        = pwm_dly;
        end else begin
            addr_ok_d = 1'b0;
        end
    end

    // One wait state: pready rises in the second access cycle
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok_d;
            prdata_out  <= (psel_in & penable_in & ~pready_out & ~pwrite_in) ?
                           rdata_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            delay_ctrl_q <= `PWMOSD_DELAY_RESET;
            steer_wr_q   <= `PWMOSD_STEER_RESET;
            mode_q       <= `PWMOSD_MODE_RESET;
            bridge_q     <= `PWMOSD_BRIDGE_RESET;
        end else if (wr_acc) begin
            if (paddr_in == `PWMOSD_DELAY_CTRL_ADDR) begin
                delay_ctrl_q <= pwdata_in[7:0];
            end else if (paddr_in == `PWMOSD_STEER_CTRL_ADDR) begin
                steer_wr_q <= pwdata_in[4:0];
            end else if (paddr_in == `PWMOSD_MODE_CTRL_ADDR) begin
                mode_q   <= pwdata_in[`PWMOSD_MODE_MSB:`PWMOSD_MODE_LSB];
                bridge_q <= pwdata_in[`PWMOSD_BRIDGE_MSB:`PWMOSD_BRIDGE_LSB];
            end
        end
    end

    // ----------------------------------------
    // Steering update timing
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            steer_act_q   <= STEER_RST[PINS-1:0];
            steer_pend_q  <= 1'b0;
            period_seen_q <= 1'b0;
        end else begin
            if (wr_acc && paddr_in == `PWMOSD_STEER_CTRL_ADDR) begin
                steer_pend_q  <= 1'b1;
                period_seen_q <= 1'b0;
            end else if (steer_pend_q) begin
                if (!steer_wr_q[`PWMOSD_SYNC_BIT]) begin
                    if (cycle_en_q) begin
                        steer_act_q  <= steer_wr_q[PINS-1:0]; // see (RL6)
                        steer_pend_q <= 1'b0;
                    end
                end else if (period_start_in || period_seen_q) begin
                    period_seen_q <= 1'b1;
                    if (cycle_en_q) begin
                        steer_act_q   <= steer_wr_q[PINS-1:0]; // see (RL2)
                        steer_pend_q  <= 1'b0;
                        period_seen_q <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Active edge delay
    // ----------------------------------------
    pwmosd_edge_delay #(
        .WIDTH       (DELAY_W)
    ) u_edge_delay (
        .clk_sys_in  (clk_sys_in),
        .reset_n_in  (reset_n_in),
        .cycle_en_in (cycle_en_q),
        .delay_in    (delay_ctrl_q[`PWMOSD_DELAY_MSB:`PWMOSD_DELAY_LSB]),
        .pwm_raw_in  (pwm_raw_in),
        .pwm_dly_out (pwm_dly)
    );

    assign steer_mode = (mode_q[3:2] == `PWMOSD_MODE_PWM_HI) &&
                        (bridge_q == `PWMOSD_BRIDGE_SINGLE); // see (RL5)

    // ----------------------------------------
    // Pin steering
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
            // Pins A and C use mode bit 1, pins B and D bit 0 (active low when set)
            always @(posedge clk_sys_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    pwm_pin_out[gi]       <= 1'b0;
                    pwm_pin_owned_out[gi] <= 1'b0;
                end else if (steer_mode && steer_act_q[gi]) begin
                    pwm_pin_out[gi]       <= pwm_dly ^ mode_q[1 - (gi % 2)]; // see (RL3)
                    pwm_pin_owned_out[gi] <= 1'b1;
                end else begin
                    pwm_pin_out[gi]       <= port_data_in[gi]; // see (RL4)
                    pwm_pin_owned_out[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            restart_enable_out <= 1'b0;
        end else begin
            restart_enable_out <= delay_ctrl_q[`PWMOSD_RESTART_BIT];
        end
    end

endmodule // pwmosd_top

/* logic/pwmosd_regs.vh */
`ifndef PWMOSD_REGS_VH
`define PWMOSD_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PWMOSD_DELAY_CTRL_ADDR   12'h000
`define PWMOSD_STEER_CTRL_ADDR   12'h004
`define PWMOSD_MODE_CTRL_ADDR    12'h008
`define PWMOSD_STATUS_ADDR       12'h00c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWMOSD_DELAY_LSB         0
`define PWMOSD_DELAY_MSB         6
`define PWMOSD_RESTART_BIT       7
`define PWMOSD_STEER_LSB         0
`define PWMOSD_STEER_MSB         3
`define PWMOSD_SYNC_BIT          4
`define PWMOSD_MODE_LSB          0
`define PWMOSD_MODE_MSB          3
`define PWMOSD_BRIDGE_LSB        4
`define PWMOSD_BRIDGE_MSB        5

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define PWMOSD_DELAY_RESET       8'h00
`define PWMOSD_STEER_RESET       5'h01
`define PWMOSD_MODE_RESET        4'h0
`define PWMOSD_BRIDGE_RESET      2'h0
`define PWMOSD_MODE_PWM_HI       2'h3
`define PWMOSD_BRIDGE_SINGLE     2'h0

// ----------------------------------------
// Timing: instruction cycle = 4 system clocks
// ----------------------------------------
`define PWMOSD_CYCLE_DIV         2'h3

`endif

/* logic/pwmosd_edge_delay.v */
`timescale 1ns/1ps
`include "pwmosd_regs.vh"

module pwmosd_edge_delay #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input  wire             clk_sys_in,
    input  wire             reset_n_in,
    // Control
    input  wire             cycle_en_in,
    input  wire [WIDTH-1:0] delay_in,
    input  wire             pwm_raw_in,
    // Result
    output reg              pwm_dly_out
);

    reg [WIDTH-1:0] count_q;
    reg             raw_q;

    // ----------------------------------------
    // Active edge postponed, inactive edge immediate
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q     <= {WIDTH{1'b0}};
            raw_q       <= 1'b0;
            pwm_dly_out <= 1'b0;
        end else if (!pwm_raw_in) begin
            raw_q       <= 1'b0;
            count_q     <= {WIDTH{1'b0}};
            pwm_dly_out <= 1'b0;
        end else if (cycle_en_in) begin
            raw_q <= 1'b1;
            if (!raw_q) begin
                count_q <= delay_in;
                if (delay_in == {WIDTH{1'b0}}) begin
                    pwm_dly_out <= 1'b1;
                end
            end else if (count_q > {{(WIDTH-1){1'b0}}, 1'b1}) begin
                count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1}; // see (RL1)
            end else begin
                count_q     <= {WIDTH{1'b0}};
                pwm_dly_out <= 1'b1; // see (RL1)
            end
        end
    end

endmodule // pwmosd_edge_delay

/* dv/pwmosd_monitor.sv */
`timescale 1ns/1ps
module pwmosd_monitor #(
    parameter DELAY_W = 7,
    parameter PINS    = 4
) (
    input wire            clk_sys_in,
    input wire            reset_n_in,
    input wire            psel_in,
    input wire            penable_in,
    input wire            pwrite_in,
    input wire [11:0]     paddr_in,
    input wire [31:0]     prdata_out,
    input wire            pready_out,
    input wire            pslverr_out,
    input wire            period_start_in,
    input wire [PINS-1:0] port_data_in,
    input wire [PINS-1:0] pwm_pin_out,
    input wire [PINS-1:0] pwm_pin_owned_out,
    input wire [31:0]     pwdata_in,
    input wire            restart_enable_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // ----------------------------------------
    // Cycles since last write or period start
    // ----------------------------------------
    logic [3:0] since_q;
    wire        wr_done = psel_in && penable_in && pwrite_in && pready_out;
    wire        bad_adr = paddr_in > 12'h00c || paddr_in[1:0] != 2'h0;
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) since_q <= 4'hf;
        else if (wr_done || period_start_in) since_q <= 4'h0;
        else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
    property p_pulse; pready_out |=> !pready_out; endproperty
    property p_wait; $rose(penable_in) && psel_in |=> pready_out; endproperty
    property p_err; pready_out && bad_adr |-> pslverr_out; endproperty
    property p_ok; pready_out && !bad_adr |-> !pslverr_out; endproperty
    property p_rdz; pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
    endproperty
    property p_port;
        pwm_pin_owned_out == 0 && $past(pwm_pin_owned_out) == 0 && $past(reset_n_in)
            |-> pwm_pin_out == $past(port_data_in);
    endproperty
    property p_steer; $changed(pwm_pin_owned_out) |-> since_q <= 4'ha; endproperty
    property p_restart;
        wr_done && paddr_in == 12'h000 |-> ##2 restart_enable_out == $past(pwdata_in[7], 2);
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_wait: assert property (p_wait) else $error("wait state count wrong");
    a_err: assert property (p_err) else $error("no error on unmapped address");
    a_ok: assert property (p_ok) else $error("error on mapped address");
    a_rdz: assert property (p_rdz) else $error("refused read data not zero");
    a_port: assert property (p_port) else $error("free pin not port data");
    a_steer: assert property (p_steer) else $error("steer change untimed");
    a_restart: assert property (p_restart) else $error("restart copy wrong");
    c_err: cover property (pready_out && pslverr_out);
    c_own: cover property ($changed(pwm_pin_owned_out));
    c_per: cover property (period_start_in ##[1:8] $changed(pwm_pin_owned_out));
endmodule // pwmosd_monitor

bind pwmosd_top pwmosd_monitor #(.DELAY_W(DELAY_W), .PINS(PINS)) mon (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .period_start_in(period_start_in), .port_data_in(port_data_in),
    .pwm_pin_out(pwm_pin_out), .pwm_pin_owned_out(pwm_pin_owned_out),
    .pwdata_in(pwdata_in), .restart_enable_out(restart_enable_out));

/* dv/pwmosd_load.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Load on pin a: counts driven rising edges
// ----------------------------------------
module pwmosd_load (
    input  wire       clk_in,
    input  wire [3:0] pin_in,
    input  wire [3:0] owned_in,
    output int        rise_a_out
);
    logic last_q = 1'b0;
    initial rise_a_out = 0;
    always @(posedge clk_in) begin
        if (owned_in[0] && pin_in[0] && !last_q) rise_a_out <= rise_a_out + 1;
        last_q <= pin_in[0];
    end
endmodule // pwmosd_load

/* dv/pwm_output_steering_delay_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
module pwm_output_steering_delay_test;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, raw = 0, per = 0;
    logic [11:0] padr = 0;
    logic [31:0] pwd = 0, rd, prd;
    logic [3:0]  port = 0, pin, own;
    logic        e, rdy, err, rsen;
    int          n_fail = 0, num_checks = 0, n, rises, r0;
    always #4 clk = ~clk;
    pwmosd_top dut (.clk_sys_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(err), .pwm_raw_in(raw), .period_start_in(per),
        .port_data_in(port), .pwm_pin_out(pin), .pwm_pin_owned_out(own),
        .restart_enable_out(rsen));
    pwmosd_load load (.clk_in(clk), .pin_in(pin), .owned_in(own), .rise_a_out(rises));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk) {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
        @(posedge clk) pen <= 1;
        do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 50);
        if (k >= 50) n_fail++;
        rd = prd; e = err; psel <= 0; pen <= 0;
    endtask
    task automatic settle(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d); repeat (12) @(posedge clk);
    endtask
    task automatic complete_run;
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    typedef struct {logic [11:0] a; logic [31:0] w, r; logic x;} row_t;
    row_t rows[5] = '{'{12'h000, 32'h0, 32'h0, 0}, '{12'h004, 32'h0, 32'h1, 0},
        '{12'h000, 32'hffffffa5, 32'ha5, 0}, '{12'h004, 32'hffffffff, 32'h1f, 0},
        '{12'h010, 32'h12345678, 32'h0, 1}};
    logic [7:0] off[5] = '{8'h1c, 8'h2c, 8'h3c, 8'h08, 8'h04};
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        foreach (rows[i]) begin
            if (i > 1) apb(1, rows[i].a, rows[i].w);
            apb(0, rows[i].a, 0); `CHK(rd, rows[i].r); `CHK(e, rows[i].x)
        end
        `CHK(rsen, 1'b1)
        apb(1, 12'h000, 0);
        settle(12'h008, 32'h0c); settle(12'h004, 32'h0f);
        `CHK(rsen, 1'b0)
        `CHK(own, 4'hf)
        `CHK(pin, 4'h0)
        raw <= 1;
        for (int m = 0; m < 4; m++) begin
            settle(12'h008, 32'h0c | m);
            `CHK(pin, {~m[0], ~m[1], ~m[0], ~m[1]})
        end
        settle(12'h008, 32'h0c); settle(12'h004, 32'h05);
        `CHK(own, 4'h5)
        `CHK(pin, 4'h5)
        foreach (off[i]) begin
            settle(12'h008, off[i]); `CHK(own, 4'h0)
        end
        apb(0, 12'h008, 0); `CHK(rd, 32'h04)
        settle(12'h008, 32'h0c); raw <= 0; settle(12'h004, 32'h01); r0 = rises;
        for (int d = 0; d < 128; d += 127) begin
            settle(12'h000, d);
            @(posedge clk) raw <= 1;
            for (n = 0; pin[0] !== 1'b1 && n < 1200; n++) @(posedge clk);
            `CHK(n >= 4 * d && n <= 4 * d + 8, 1'b1)
            @(posedge clk) raw <= 0; repeat (12) @(posedge clk);
        end
        `CHK(rises - r0, 2)
        settle(12'h004, 32'h13); repeat (8) @(posedge clk);
        `CHK(own, 4'h1)
        apb(0, 12'h00c, 0); `CHK(rd, 32'h11)
        @(posedge clk) per <= 1; @(posedge clk) per <= 0; repeat (8) @(posedge clk);
        `CHK(own, 4'h3)
        rst_n <= 0; port <= 4'ha; repeat (2) @(posedge clk);
        `CHK(own, 4'h0)
        `CHK(pin, 4'h0)
        rst_n <= 1; repeat (2) @(posedge clk);
        `CHK(own, 4'h0)
        `CHK(pin, 4'ha)
        apb(0, 12'h000, 0); `CHK(rd, 32'h0)
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule // pwm_output_steering_delay_test
